// >>> src/sdcd_decoder.sv
// Decoder for source-one doubleword three and compact detection.
// Assumes fetch presents a 128-bit word with a one-cycle valid, and that
// address and access mode of source one come from other decode logic.
`timescale 1ns/1ps
`include "sdcd_map.svh"
module sdcd_decoder (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input wire logic [127:0] instr_i,
  input wire logic src0_is_imm_i,
  input wire logic src1_is_imm_i,
  input wire logic is_send_i,
  input wire logic src1_indirect_i,
  input wire logic four_channel_layout_i,
  input wire logic tbl_wr_en_i,
  input wire logic [2:0] tbl_sel_i,
  input wire logic [4:0] tbl_wr_idx_i,
  input wire logic [18:0] tbl_wr_data_i,
  output logic out_valid_o,
  output logic [127:0] native_instr_o,
  output logic is_compact_o,
  output logic [1:0] ip_advance_o,
  output logic src0_imm_valid_o,
  output logic src1_imm_valid_o,
  output logic [31:0] immediate_word_o,
  output logic end_of_thread_o,
  output logic [30:0] message_descriptor_low_o,
  output logic src1_reg_valid_o,
  output logic [1:0] layout_o,
  output logic [3:0] vertical_stride_o,
  output logic [3:0] channel_select_o,
  output logic [1:0] source_modifier_o,
  output logic [7:0] register_number_o,
  output logic [4:0] subregister_number_o,
  output logic [3:0] channel_enable_o,
  output logic [2:0] width_o,
  output logic [1:0] horizontal_stride_o,
  output logic addressing_mode_bit_o,
  output logic [2:0] address_register_subindex_o,
  output logic [9:0] address_immediate_offset_o
);
  // ************************************************
  // Compact detection and expansion
  // ************************************************
  wire compact = instr_i[`SDCD_CMPT_BIT];
  wire [11:0] s1_map;
  wire [11:0] s0_map;
  wire [14:0] sr_map;
  wire [17:0] dt_map;
  wire [18:0] ct_map;
  sdcd_index_table #(.WIDTH(12)) u_src1_tbl (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .wr_en_i(tbl_wr_en_i && tbl_sel_i == 3'h0), .wr_idx_i(tbl_wr_idx_i), .wr_data_i(tbl_wr_data_i[11:0]),
    .rd_idx_i(instr_i[39:35]), .rd_data_o(s1_map));
  sdcd_index_table #(.WIDTH(12)) u_src0_tbl (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .wr_en_i(tbl_wr_en_i && tbl_sel_i == 3'h1), .wr_idx_i(tbl_wr_idx_i), .wr_data_i(tbl_wr_data_i[11:0]),
    .rd_idx_i(instr_i[34:30]), .rd_data_o(s0_map));
  sdcd_index_table #(.WIDTH(15)) u_subreg_tbl (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .wr_en_i(tbl_wr_en_i && tbl_sel_i == 3'h2), .wr_idx_i(tbl_wr_idx_i), .wr_data_i(tbl_wr_data_i[14:0]),
    .rd_idx_i(instr_i[22:18]), .rd_data_o(sr_map));
  sdcd_index_table #(.WIDTH(18)) u_dtype_tbl (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .wr_en_i(tbl_wr_en_i && tbl_sel_i == 3'h3), .wr_idx_i(tbl_wr_idx_i), .wr_data_i(tbl_wr_data_i[17:0]),
    .rd_idx_i(instr_i[17:13]), .rd_data_o(dt_map));
  sdcd_index_table #(.WIDTH(19)) u_ctrl_tbl (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .wr_en_i(tbl_wr_en_i && tbl_sel_i == 3'h4), .wr_idx_i(tbl_wr_idx_i), .wr_data_i(tbl_wr_data_i),
    .rd_idx_i(instr_i[12:8]), .rd_data_o(ct_map));

  // Immediate src1 bypasses its table and sign-extends the index
  wire [127:0] expanded;
  assign expanded[127:109] = src1_is_imm_i ? {19{instr_i[39]}} : {7'h00, s1_map};
  assign expanded[108:101] = src1_is_imm_i ? {instr_i[39:35], instr_i[63:61]} : instr_i[63:56];
  assign expanded[100:96] = src1_is_imm_i ? instr_i[60:56] : sr_map[14:10];
  assign expanded[95:91] = 5'h00;
  assign expanded[90:89] = ct_map[18:17];
  assign expanded[88:77] = s0_map;
  assign expanded[76:69] = instr_i[55:48];
  assign expanded[68:64] = sr_map[9:5];
  assign expanded[63:61] = dt_map[17:15];
  assign expanded[60:53] = instr_i[47:40];
  assign expanded[52:48] = sr_map[4:0];
  assign expanded[47] = 1'b0;
  assign expanded[46:32] = dt_map[14:0];
  assign expanded[31] = ct_map[16];
  assign expanded[30] = instr_i[7];
  assign expanded[29] = 1'b0;
  assign expanded[28] = instr_i[23];
  assign expanded[27:24] = instr_i[27:24];
  assign expanded[23:8] = ct_map[15:0];
  assign expanded[7] = 1'b0;
  assign expanded[6:0] = instr_i[6:0];
  wire [127:0] native = compact ? expanded : instr_i;

  // ************************************************
  // Doubleword three decode
  // ************************************************
  wire [31:0] dw3 = native[127:96];
  wire any_imm = src0_is_imm_i || src1_is_imm_i;
  wire src1_reg = !src1_is_imm_i && !src0_is_imm_i;
  sdcd_pkg::sdcd_layout_t layout;
  assign layout = sdcd_pkg::sdcd_layout_t'({src1_indirect_i, !four_channel_layout_i});
  wire [3:0] f_vs;
  wire [3:0] f_cs;
  wire [1:0] f_sm;
  wire [7:0] f_rn;
  wire [4:0] f_sr;
  wire [3:0] f_ce;
  wire [2:0] f_w;
  wire [1:0] f_hs;
  wire f_am;
  wire [2:0] f_as;
  wire [9:0] f_ai;
  sdcd_field_split u_split (.dword_i(dw3), .layout_i(layout),
    .vertical_stride_o(f_vs), .channel_select_o(f_cs), .source_modifier_o(f_sm),
    .register_number_o(f_rn), .subregister_number_o(f_sr), .channel_enable_o(f_ce),
    .width_o(f_w), .horizontal_stride_o(f_hs), .addressing_mode_bit_o(f_am),
    .address_register_subindex_o(f_as), .address_immediate_offset_o(f_ai));

  // Send register source is fixed to address zero by the producer
  wire nxt_eot = is_send_i && dw3[`SDCD_EOT_BIT];
  wire [30:0] nxt_desc = (is_send_i && src1_is_imm_i) ? dw3[30:0] : 31'h0;
  // Send immediate word excludes the end-of-thread bit
  wire [31:0] nxt_imm = !any_imm ? 32'h0 :
    (is_send_i ? {1'b0, dw3[30:0]} : dw3);
  wire reg_fields = src1_reg && !is_send_i;

  // ************************************************
  // Output registers
  // ************************************************
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      out_valid_o <= 1'b0;
      native_instr_o <= 128'h0;
      is_compact_o <= 1'b0;
      ip_advance_o <= 2'h0;
      src0_imm_valid_o <= 1'b0;
      src1_imm_valid_o <= 1'b0;
      immediate_word_o <= 32'h0;
      end_of_thread_o <= 1'b0;
      message_descriptor_low_o <= 31'h0;
      src1_reg_valid_o <= 1'b0;
      layout_o <= 2'h0;
      vertical_stride_o <= 4'h0;
      channel_select_o <= 4'h0;
      source_modifier_o <= 2'h0;
      register_number_o <= 8'h0;
      subregister_number_o <= 5'h0;
      channel_enable_o <= 4'h0;
      width_o <= 3'h0;
      horizontal_stride_o <= 2'h0;
      addressing_mode_bit_o <= 1'b0;
      address_register_subindex_o <= 3'h0;
      address_immediate_offset_o <= 10'h0;
    end else begin
      out_valid_o <= instr_valid_i;
      if (instr_valid_i) begin
        native_instr_o <= native;
        is_compact_o <= compact;
        ip_advance_o <= compact ? `SDCD_IP_COMPACT : `SDCD_IP_NATIVE;
        src0_imm_valid_o <= src0_is_imm_i;
        src1_imm_valid_o <= src1_is_imm_i;
        immediate_word_o <= nxt_imm;
        end_of_thread_o <= nxt_eot;
        message_descriptor_low_o <= nxt_desc;
        src1_reg_valid_o <= reg_fields;
        layout_o <= layout;
        vertical_stride_o <= reg_fields ? f_vs : 4'h0;
        channel_select_o <= reg_fields ? f_cs : 4'h0;
        source_modifier_o <= reg_fields ? f_sm : 2'h0;
        register_number_o <= reg_fields ? f_rn : 8'h0;
        subregister_number_o <= reg_fields ? f_sr : 5'h0;
        channel_enable_o <= reg_fields ? f_ce : 4'h0;
        width_o <= reg_fields ? f_w : 3'h0;
        horizontal_stride_o <= reg_fields ? f_hs : 2'h0;
        addressing_mode_bit_o <= reg_fields ? f_am : 1'b0;
        address_register_subindex_o <= reg_fields ? f_as : 3'h0;
        address_immediate_offset_o <= reg_fields ? f_ai : 10'h0;
      end
    end
  end

  // ************************************************
  // Checks
  // ************************************************
  sequence s_take_compact;
    instr_valid_i && instr_i[`SDCD_CMPT_BIT];
  endsequence
  a_compact_flag: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_take_compact |=> is_compact_o && out_valid_o) else $error("compact flag missed");
  a_ip_units: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    out_valid_o |-> ip_advance_o == (is_compact_o ? 2'h1 : 2'h2)) else $error("ip advance wrong");
  a_src1_imm_word: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    instr_valid_i && src1_is_imm_i && !is_send_i |=> immediate_word_o == $past(native[127:96]))
    else $error("src1 immediate wrong");
  a_src0_imm_word: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    instr_valid_i && src0_is_imm_i && !is_send_i |=> immediate_word_o == $past(native[127:96]))
    else $error("src0 immediate wrong");
  a_eot_bit: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    instr_valid_i && is_send_i |=> end_of_thread_o == $past(native[127])) else $error("eot wrong");
  a_desc_low: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    instr_valid_i && is_send_i && src1_is_imm_i |=> message_descriptor_low_o == $past(native[126:96]))
    else $error("descriptor wrong");
  a_imm_no_regs: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    instr_valid_i && src1_is_imm_i |=> register_number_o == 8'h0 && channel_enable_o == 4'h0)
    else $error("register fields leaked");
  a_direct_register_number: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    instr_valid_i && reg_fields && !src1_indirect_i |=> register_number_o == $past(native[108:101]))
    else $error("register number wrong");
  a_ind_scal_imm: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    instr_valid_i && reg_fields && src1_indirect_i && !four_channel_layout_i
    |=> address_immediate_offset_o == $past(native[105:96])) else $error("address immediate wrong");
  a_native_pass: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    instr_valid_i && !instr_i[`SDCD_CMPT_BIT] |=> native_instr_o == $past(instr_i))
    else $error("native not passed");
endmodule

// >>> src/sdcd_field_split.sv
// Splits doubleword three into its register-operand fields.
// Assumes a layout code from the caller; purely combinational.
`timescale 1ns/1ps
`include "sdcd_map.svh"
module sdcd_field_split (
  input wire logic [31:0] dword_i,
  input wire sdcd_pkg::sdcd_layout_t layout_i,
  output logic [3:0] vertical_stride_o,
  output logic [3:0] channel_select_o,
  output logic [1:0] source_modifier_o,
  output logic [7:0] register_number_o,
  output logic [4:0] subregister_number_o,
  output logic [3:0] channel_enable_o,
  output logic [2:0] width_o,
  output logic [1:0] horizontal_stride_o,
  output logic addressing_mode_bit_o,
  output logic [2:0] address_register_subindex_o,
  output logic [9:0] address_immediate_offset_o
);
  wire is_scal = (layout_i == sdcd_pkg::SDCD_DIR_SCAL) || (layout_i == sdcd_pkg::SDCD_IND_SCAL);
  wire is_ind = (layout_i == sdcd_pkg::SDCD_IND_FOUR) || (layout_i == sdcd_pkg::SDCD_IND_SCAL);
  // Fields shared by every layout
  assign vertical_stride_o = dword_i[`SDCD_VSTRIDE_HI:`SDCD_VSTRIDE_LO];
  assign source_modifier_o = dword_i[`SDCD_SMOD_HI:`SDCD_SMOD_LO];
  // Register number only exists when direct
  assign register_number_o = is_ind ? 8'h00 : dword_i[`SDCD_REGISTER_NUMBER_HI:`SDCD_REGISTER_NUMBER_LO];
  assign channel_select_o = is_scal ? 4'h0 : dword_i[`SDCD_CHSEL_HI:`SDCD_CHSEL_LO];
  assign channel_enable_o = is_scal ? 4'h0 : dword_i[3:0];
  assign width_o = is_scal ? dword_i[`SDCD_WIDTH_HI:`SDCD_WIDTH_LO] : 3'h0;
  assign horizontal_stride_o = is_scal ? dword_i[`SDCD_HSTRIDE_HI:`SDCD_HSTRIDE_LO] : 2'h0;
  assign subregister_number_o = is_ind ? 5'h00 : (is_scal ? dword_i[4:0] : {dword_i[4], 4'h0});
  assign addressing_mode_bit_o = is_ind ? dword_i[`SDCD_AMODE_BIT] : 1'b0;
  assign address_register_subindex_o = is_ind ? dword_i[`SDCD_ASUB_HI:`SDCD_ASUB_LO] : 3'h0;
  // Four-channel offset is half-register aligned, low nibble zero
  assign address_immediate_offset_o = !is_ind ? 10'h000 :
    (is_scal ? dword_i[9:0] : {dword_i[9:4], 4'h0});
endmodule

// >>> src/sdcd_index_table.sv
// Compaction lookup table: index to expanded bit group.
// Table contents are loaded by software-visible config ports; reset clears.
`timescale 1ns/1ps
`include "sdcd_map.svh"
module sdcd_index_table #(
  parameter int WIDTH = 12,
  parameter int ENTRIES = `SDCD_IDX_ENTRIES
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic wr_en_i,
  input wire logic [4:0] wr_idx_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic [4:0] rd_idx_i,
  output logic [WIDTH-1:0] rd_data_o
);
  logic [WIDTH-1:0] entry_ff [ENTRIES];
  genvar gi;
  generate
    for (gi = 0; gi < ENTRIES; gi++) begin : g_entry
      always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
          entry_ff[gi] <= '0;
        end else if (wr_en_i && (wr_idx_i == 5'(gi))) begin
          entry_ff[gi] <= wr_data_i;
        end
      end
    end
  endgenerate
  assign rd_data_o = entry_ff[rd_idx_i];
endmodule

// >>> src/sdcd_map.svh
// Constants for the source-one doubleword and compact-form decoder.
// Assumes inclusion by bare name from design files only.
`ifndef SDCD_MAP_SVH
`define SDCD_MAP_SVH
`define SDCD_CMPT_BIT 29
`define SDCD_EOT_BIT 31
`define SDCD_VSTRIDE_HI 24
`define SDCD_VSTRIDE_LO 21
`define SDCD_WIDTH_HI 20
`define SDCD_WIDTH_LO 18
`define SDCD_HSTRIDE_HI 17
`define SDCD_HSTRIDE_LO 16
`define SDCD_CHSEL_HI 19
`define SDCD_CHSEL_LO 16
`define SDCD_AMODE_BIT 15
`define SDCD_SMOD_HI 14
`define SDCD_SMOD_LO 13
`define SDCD_REGISTER_NUMBER_HI 12
`define SDCD_REGISTER_NUMBER_LO 5
`define SDCD_ASUB_HI 12
`define SDCD_ASUB_LO 10
`define SDCD_IP_COMPACT 2'h1
`define SDCD_IP_NATIVE 2'h2
`define SDCD_IDX_ENTRIES 32
`endif

// >>> src/sdcd_pkg.sv
// Types shared by the decoder files.
// Assumes no other package.
package sdcd_pkg;
  typedef enum logic [1:0] {
    SDCD_DIR_FOUR = 2'b00,
    SDCD_DIR_SCAL = 2'b01,
    SDCD_IND_FOUR = 2'b10,
    SDCD_IND_SCAL = 2'b11
  } sdcd_layout_t;
endpackage

// >>> verification/sdcd_decoder_test.sv
// Self-checking bench for the doubleword-three and compact decoder.
// Assumes the design files and the fetch model are compiled first.
`timescale 1ns/1ps
module sdcd_decoder_test;
  localparam logic [95:0] LOW = 96'h1234_5678_9abc_def0_0f0f_0f0f;
  localparam logic [63:0] CW = {8'h3c, 8'h5a, 8'h96, 5'h1a, 5'h05, 1'b1, 1'b0, 4'h9, 1'b1, 15'h0000, 1'b1, 7'h31};
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic push = 1'b0;
  logic [127:0] word = '0;
  logic [1:0] delay = 2'h0;
  logic [4:0] sb = 5'h00;
  logic tbl_wr_en = 1'b0;
  logic [2:0] tbl_sel = 3'h0;
  logic [4:0] tbl_idx = 5'h00;
  logic [18:0] tbl_data = 19'h00000;
  logic instr_valid, out_valid, is_compact, s0v, s1v, end_of_thread, regv, am;
  logic [127:0] instr, native;
  logic [1:0] ip_adv, layout, sm, hs;
  logic [31:0] imm, d;
  logic [30:0] msg;
  logic [3:0] vs, cs, ce;
  logic [7:0] rn;
  logic [4:0] sr, s;
  logic [2:0] wd, asub;
  logic [9:0] aimm;
  wire [45:0] fields = {vs, cs, sm, rn, sr, ce, wd, hs, am, asub, aimm};
  // Sideband bits: src0 imm, src1 imm, send, indirect, four-channel
  logic [31:0] dws [10] = '{32'h01f5_7aa9, 32'h01b7_2c5e, 32'h00fb_d3a7, 32'h0163_e9c6, 32'hdead_beef,
    32'h8000_0001, 32'hc123_4567, 32'h8000_0000, 32'h7000_0000, 32'h9abc_0123};
  logic [4:0] sbs [10] = '{5'h01, 5'h00, 5'h03, 5'h02, 5'h11, 5'h0a, 5'h0c, 5'h04, 5'h04, 5'h15};
  int err_total = 0;
  int checked = 0;
  sdcd_fetch_model fetch (.core_clk_i(core_clk_i), .push_i(push), .word_i(word), .delay_i(delay),
    .instr_valid_o(instr_valid), .instr_o(instr));
  sdcd_decoder uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid), .instr_i(instr),
    .src0_is_imm_i(sb[4]), .src1_is_imm_i(sb[3]), .is_send_i(sb[2]), .src1_indirect_i(sb[1]),
    .four_channel_layout_i(sb[0]), .tbl_wr_en_i(tbl_wr_en), .tbl_sel_i(tbl_sel), .tbl_wr_idx_i(tbl_idx),
    .tbl_wr_data_i(tbl_data), .out_valid_o(out_valid), .native_instr_o(native), .is_compact_o(is_compact),
    .ip_advance_o(ip_adv), .src0_imm_valid_o(s0v), .src1_imm_valid_o(s1v), .immediate_word_o(imm),
    .end_of_thread_o(end_of_thread), .message_descriptor_low_o(msg), .src1_reg_valid_o(regv), .layout_o(layout),
    .vertical_stride_o(vs), .channel_select_o(cs), .source_modifier_o(sm), .register_number_o(rn),
    .subregister_number_o(sr), .channel_enable_o(ce), .width_o(wd), .horizontal_stride_o(hs),
    .addressing_mode_bit_o(am), .address_register_subindex_o(asub), .address_immediate_offset_o(aimm));
  // *******
  // Helpers
  // *******
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  function automatic logic [45:0] exp_fields(input logic [31:0] x, input logic [4:0] m);
    logic ind = m[1];
    logic sc = !m[0];
    if (m[4] || m[3] || m[2]) return '0;
    return {x[24:21], sc ? 4'h0 : x[19:16], x[14:13], ind ? 8'h00 : x[12:5],
      ind ? 5'h00 : (sc ? x[4:0] : {x[4], 4'h0}), sc ? 4'h0 : x[3:0], sc ? x[20:18] : 3'h0,
      sc ? x[17:16] : 2'h0, ind & x[15], ind ? x[12:10] : 3'h0,
      ind ? (sc ? x[9:0] : {x[9:4], 4'h0}) : 10'h000};
  endfunction
  task automatic check(input logic [255:0] seen, input logic [255:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic send_word(input logic [127:0] w, input logic [4:0] m, input logic [1:0] dl);
    @(posedge core_clk_i);
    push <= 1'b1;
    word <= w;
    sb <= m;
    delay <= dl;
    @(posedge core_clk_i);
    push <= 1'b0;
  endtask
  // Bounded wait; a missing answer shows up as a failed compare
  task automatic wait_out;
    int n = 0;
    @(posedge core_clk_i);
    #1;
    while (out_valid !== 1'b1 && n < 10) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    check(out_valid, 1'b1);
  endtask
  task automatic do_reset(input int n);
    @(posedge core_clk_i);
    rst_n_i <= 1'b0;
    repeat (n) @(posedge core_clk_i);
    #1;
    check({out_valid, is_compact, ip_adv, native, imm, fields, s0v, s1v, end_of_thread, msg, regv, layout}, '0);
    @(posedge core_clk_i);
    rst_n_i <= 1'b1;
  endtask
  task automatic compact_check(input logic [11:0] e);
    send_word({64'h5555_aaaa_5555_aaaa, CW}, 5'h00, 2'h1);
    wait_out();
    check({is_compact, ip_adv}, 3'h5);
    check({native[108:101], native[88:77], native[76:69], native[60:53], native[30:24], native[6:0]},
      {8'h3c, e, 8'h5a, 8'h96, 7'h59, 7'h31});
  endtask
  task automatic report_and_stop;
    $display("Checks %0d, errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    report_and_stop();
  end
  // *****
  // Tests
  // *****
  initial begin
    do_reset(10);
    for (int i = 0; i < 10; i++) begin
      d = dws[i];
      s = sbs[i];
      send_word({d, LOW}, s, 2'(i % 3));
      wait_out();
      check(native, {d, LOW});
      check({is_compact, ip_adv}, 3'h2);
      check({s0v, s1v, layout}, {s[4], s[3], s[1], !s[0]});
      check(fields, exp_fields(d, s));
      check(regv, !(s[4] | s[3] | s[2]));
      check(imm, (s[4] | s[3]) ? (s[2] ? {1'b0, d[30:0]} : d) : 32'h0);
      check({end_of_thread, msg}, {s[2] & d[31], (s[2] & s[3]) ? d[30:0] : 31'h0});
      @(posedge core_clk_i);
      #1;
      check(out_valid, 1'b0);
    end
    // Back-to-back words with no gap
    @(posedge core_clk_i);
    push <= 1'b1;
    word <= {dws[0], LOW};
    sb <= 5'h01;
    delay <= 2'h0;
    @(posedge core_clk_i);
    word <= {dws[1], LOW};
    @(posedge core_clk_i);
    push <= 1'b0;
    wait_out();
    check(native, {dws[0], LOW});
    @(posedge core_clk_i);
    #1;
    check({out_valid, fields}, {1'b1, exp_fields(dws[1], 5'h01)});
    // Table entry feeds the rebuilt instruction
    @(posedge core_clk_i);
    tbl_wr_en <= 1'b1;
    tbl_sel <= 3'h1;
    tbl_idx <= 5'h05;
    tbl_data <= 19'h00abc;
    @(posedge core_clk_i);
    tbl_wr_en <= 1'b0;
    compact_check(12'habc);
    send_word({64'h0, CW}, 5'h08, 2'h0);
    wait_out();
    check(native[127:104], {19'h7ffff, 5'h1a});
    // Reset in mid-run clears outputs and tables
    do_reset(2);
    compact_check(12'h000);
    report_and_stop();
  end
endmodule

// >>> verification/sdcd_fetch_model.sv
// Fetch-side model that hands 128-bit words to the decoder.
// Assumes the bench pushes one whole word at a time on its push strobe.
`timescale 1ns/1ps
module sdcd_fetch_model (
  input wire logic core_clk_i,
  input wire logic push_i,
  input wire logic [127:0] word_i,
  input wire logic [1:0] delay_i,
  output logic instr_valid_o,
  output logic [127:0] instr_o
);
  // ********
  // Delivery
  // ********
  logic pend_ff = 1'b0;
  logic [1:0] cnt_ff = 2'h0;
  logic [127:0] word_ff = '0;
  logic valid_ff = 1'b0;
  logic [127:0] bus_ff = '0;
  assign instr_valid_o = valid_ff;
  assign instr_o = bus_ff;
  // Words arrive already encoded: register send sources and three-source forms as required
  always_ff @(posedge core_clk_i) begin
    valid_ff <= 1'b0;
    // Idle bus scrambles so a stale word never looks valid
    bus_ff <= ~bus_ff;
    if (pend_ff) begin
      if (cnt_ff == 2'h0) begin
        valid_ff <= 1'b1;
        bus_ff <= word_ff;
        pend_ff <= 1'b0;
      end else begin
        cnt_ff <= cnt_ff - 2'h1;
      end
    end
    if (push_i) begin
      pend_ff <= 1'b1;
      word_ff <= word_i;
      cnt_ff <= delay_i;
    end
  end
endmodule
